// ==== logic/ccp_channel_control.sv ====
// Channel control register with pattern generator, checker and loop-back steering
`timescale 1ns/1ps
module ccp_channel_control (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    output logic [7:0] reg_rd_data,
    // System transmit side
    input wire logic tx_clock_in,
    input wire logic tx_positive_in,
    input wire logic tx_negative_in,
    // Line transmit side
    output ccp_pkg::ccp_rails_s tx_line,
    // Recovered receive data
    input wire logic rx_bit_en,
    input wire ccp_pkg::ccp_rails_s rx_line,
    input wire logic rx_code_violation,
    // System receive side
    output logic rx_positive_out,
    output logic rx_negative_out,
    output logic neg_rail_violation_out,
    // Status and configuration
    output logic coder_enable,
    output ccp_pkg::ccp_rate_e rate_mode,
    output ccp_pkg::ccp_loop_e loop_mode,
    output logic [15:0] prbs_error_count
);
    import ccp_pkg::*;

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    ccp_ctrl_s ctrl, next_ctrl;
    logic single_rail;

    always_comb begin
        next_ctrl = ctrl;
        if (reg_wr_en) begin
            next_ctrl = ccp_ctrl_s'(reg_wr_data & CCP_CTRL_WR_MASK);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            ctrl <= ccp_ctrl_s'(CCP_CTRL_RESET);
        end else begin
            ctrl <= next_ctrl;
        end
    end

    assign reg_rd_data = {2'b00, ctrl[5:0]};

    always_comb begin
        if (ctrl.rate_e_mode_sel) begin
            rate_mode = CCP_RATE_E3;
        end else if (ctrl.sonet_vs_t_rate_sel) begin
            rate_mode = CCP_RATE_STS1;
        end else begin
            rate_mode = CCP_RATE_DS3;
        end
    end

    assign loop_mode = ccp_loop_e'({ctrl.local_loop_sel, ctrl.remote_loop_sel});
    // Pattern testing forces single-rail regardless of the stored bit
    assign single_rail = ctrl.rail_format_sel | ctrl.prbs_enable;
    assign coder_enable = single_rail;

    // ---------------------------------------------------------------
    // Transmit clock synchroniser
    // ---------------------------------------------------------------
    logic txc_s1, txc_s2, txc_s3;
    logic txp_s1, txp_s2, txn_s1, txn_s2;
    logic tx_bit_en;

    // Data pins are retimed through two stages, the clock stage the edge is detected at, so data and bit strobe stay aligned
    always_ff @(posedge clock) begin
        if (rst) begin
            txc_s1 <= 1'b0;
            txc_s2 <= 1'b0;
            txc_s3 <= 1'b0;
            txp_s1 <= 1'b0;
            txp_s2 <= 1'b0;
            txn_s1 <= 1'b0;
            txn_s2 <= 1'b0;
        end else begin
            txc_s1 <= tx_clock_in;
            txc_s2 <= txc_s1;
            txc_s3 <= txc_s2;
            txp_s1 <= tx_positive_in;
            txp_s2 <= txp_s1;
            txn_s1 <= tx_negative_in;
            txn_s2 <= txn_s1;
        end
    end

    // Bit timing relies on the system clock staying clean while patterns run
    assign tx_bit_en = txc_s2 & ~txc_s3;

    // ---------------------------------------------------------------
    // Generator and transmit data path
    // ---------------------------------------------------------------
    logic [22:0] gen_lfsr, next_gen_lfsr;
    logic gen_bit;
    ccp_rails_s next_tx_line;
    ccp_rails_s rx_hold, next_rx_hold;

    // Shared 23-bit register; short sequence uses its low 15 stages
    function automatic logic lfsr_fb(input logic [22:0] s, input logic e3);
        lfsr_fb = e3 ? (s[CCP_P23_TAP_A] ^ s[CCP_P23_TAP_B]) : (s[CCP_P15_TAP_A] ^ s[CCP_P15_TAP_B]);
    endfunction

    assign gen_bit = lfsr_fb(gen_lfsr, ctrl.rate_e_mode_sel);

    always_comb begin
        next_gen_lfsr = gen_lfsr;
        next_tx_line = tx_line;
        if (!ctrl.prbs_enable) begin
            next_gen_lfsr = CCP_LFSR_SEED;
        end
        if (tx_bit_en) begin
            if (ctrl.prbs_enable) begin
                next_gen_lfsr = {gen_lfsr[21:0], gen_bit};
                next_tx_line = '{pos: gen_bit, neg: 1'b0};
            end else if (loop_mode == CCP_LOOP_REMOTE) begin
                next_tx_line = rx_hold;
            end else if (single_rail) begin
                next_tx_line = '{pos: txp_s2, neg: 1'b0};
            end else begin
                next_tx_line = '{pos: txp_s2, neg: txn_s2};
            end
        end
    end

    // ---------------------------------------------------------------
    // Receive source and checker
    // ---------------------------------------------------------------
    ccp_rails_s rx_src;
    logic rx_src_en;
    logic [22:0] chk_lfsr, next_chk_lfsr;
    logic [4:0] sync_cnt, next_sync_cnt;
    logic [15:0] next_err_count;
    logic chk_err;
    logic next_rx_pos, next_rx_neg, next_viol;

    // Digital local loop feeds transmitted bits straight back to the receiver
    always_comb begin
        if (loop_mode == CCP_LOOP_DIGITAL) begin
            rx_src = next_tx_line;
            rx_src_en = tx_bit_en;
        end else begin
            rx_src = rx_line;
            rx_src_en = rx_bit_en;
        end
    end

    // Self-synchronising check: prediction from the last received bits
    assign chk_err = rx_src.pos ^ lfsr_fb(chk_lfsr, ctrl.rate_e_mode_sel);

    always_comb begin
        next_rx_hold = rx_hold;
        next_chk_lfsr = chk_lfsr;
        next_sync_cnt = sync_cnt;
        next_err_count = prbs_error_count;
        next_rx_pos = rx_positive_out;
        next_rx_neg = rx_negative_out;
        next_viol = neg_rail_violation_out;
        if (!ctrl.prbs_enable) begin
            next_sync_cnt = CCP_SYNC_BITS;
        end
        if (rx_src_en) begin
            next_rx_hold = rx_src;
            next_rx_pos = rx_src.pos;
            next_rx_neg = single_rail ? 1'b0 : rx_src.neg;
            next_viol = single_rail ? rx_code_violation : 1'b0;
            if (ctrl.prbs_enable) begin
                next_chk_lfsr = {chk_lfsr[21:0], rx_src.pos};
                // Errors are masked until the register has been refilled from the line
                if (sync_cnt != 5'h00) begin
                    next_sync_cnt = sync_cnt - 5'h01;
                    next_viol = 1'b0;
                end else begin
                    next_viol = chk_err;
                    if (chk_err && prbs_error_count != CCP_CNT_MAX) begin
                        next_err_count = prbs_error_count + 16'h0001;
                    end
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Data path registers
    // ---------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (rst) begin
            gen_lfsr <= CCP_LFSR_SEED;
            tx_line <= '{pos: 1'b0, neg: 1'b0};
            rx_hold <= '{pos: 1'b0, neg: 1'b0};
            chk_lfsr <= '0;
            sync_cnt <= CCP_SYNC_BITS;
            prbs_error_count <= '0;
            rx_positive_out <= 1'b0;
            rx_negative_out <= 1'b0;
            neg_rail_violation_out <= 1'b0;
        end else begin
            gen_lfsr <= next_gen_lfsr;
            tx_line <= next_tx_line;
            rx_hold <= next_rx_hold;
            chk_lfsr <= next_chk_lfsr;
            sync_cnt <= next_sync_cnt;
            prbs_error_count <= next_err_count;
            rx_positive_out <= next_rx_pos;
            rx_negative_out <= next_rx_neg;
            neg_rail_violation_out <= next_viol;
        end
    end

endmodule

// ==== logic/ccp_pkg.sv ====
// Package for the channel control, pattern test and loop-back block
package ccp_pkg;

    // ---------------------------------------------------------------
    // Register layout
    // ---------------------------------------------------------------
    localparam int CCP_REG_W = 8;
    localparam logic [7:0] CCP_CTRL_RESET = 8'h00;
    localparam logic [7:0] CCP_CTRL_WR_MASK = 8'h3F;
    localparam int CCP_BIT_RAIL = 0;
    localparam int CCP_BIT_SONET = 1;
    localparam int CCP_BIT_E3 = 2;
    localparam int CCP_BIT_LOCAL = 3;
    localparam int CCP_BIT_REMOTE = 4;
    localparam int CCP_BIT_PRBS = 5;

    // ---------------------------------------------------------------
    // Pattern generator and checker
    // ---------------------------------------------------------------
    localparam int CCP_LFSR_W = 23;
    localparam int CCP_P15_TAP_A = 14;
    localparam int CCP_P15_TAP_B = 13;
    localparam int CCP_P23_TAP_A = 22;
    localparam int CCP_P23_TAP_B = 17;
    localparam logic [22:0] CCP_LFSR_SEED = 23'h7FFFFF;
    localparam int CCP_CNT_W = 16;
    localparam logic [15:0] CCP_CNT_MAX = 16'hFFFF;
    localparam logic [4:0] CCP_SYNC_BITS = 5'h17;

    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum logic [1:0] {
        CCP_RATE_DS3 = 2'b00,
        CCP_RATE_STS1 = 2'b01,
        CCP_RATE_E3 = 2'b10
    } ccp_rate_e;

    typedef enum logic [1:0] {
        CCP_LOOP_NONE = 2'b00,
        CCP_LOOP_REMOTE = 2'b01,
        CCP_LOOP_ANALOG = 2'b10,
        CCP_LOOP_DIGITAL = 2'b11
    } ccp_loop_e;

    typedef struct packed {
        logic [1:0] reserved;
        logic prbs_enable;
        logic remote_loop_sel;
        logic local_loop_sel;
        logic rate_e_mode_sel;
        logic sonet_vs_t_rate_sel;
        logic rail_format_sel;
    } ccp_ctrl_s;

    typedef struct packed {
        logic pos;
        logic neg;
    } ccp_rails_s;

endpackage

// ==== bench/ccp_framer_model.sv ====
// System-side framer model: transmit clock and data
`timescale 1ns/1ps
module ccp_framer_model (
    // Clock
    input wire logic clock,
    // Framer outputs
    output logic tx_clock_in,
    output logic tx_positive_in,
    output logic tx_negative_in
);
    logic [2:0] ph = 3'h0;
    initial begin
        tx_clock_in = 1'b0;
        tx_positive_in = 1'b0;
        tx_negative_in = 1'b1;
    end
    // Steady 8-cycle bit clock, never paused, so test mode always has a clock
    always @(posedge clock) begin
        ph <= ph + 3'h1;
        tx_clock_in <= ph[2];
        if (ph == 3'h7) begin
            tx_positive_in <= ~tx_positive_in;
            tx_negative_in <= tx_positive_in;
        end
    end
endmodule

// ==== bench/ccp_channel_control_checker.sv ====
// Port assertions for the channel control block
`timescale 1ns/1ps
module ccp_channel_control_checker
    import ccp_pkg::*;
(
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Register port
    input wire logic reg_wr_en,
    input wire logic [7:0] reg_wr_data,
    input wire logic [7:0] reg_rd_data,
    // Data path
    input wire logic rx_bit_en,
    input wire ccp_pkg::ccp_rails_s tx_line,
    input wire logic neg_rail_violation_out,
    // Status
    input wire logic coder_enable,
    input wire ccp_pkg::ccp_rate_e rate_mode,
    input wire ccp_pkg::ccp_loop_e loop_mode,
    input wire logic [15:0] prbs_error_count
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);
    a_write_readback: assert property (reg_wr_en |=> reg_rd_data == ($past(reg_wr_data) & 8'h3F))
        else $error("readback differs from write");
    a_reserved_zero: assert property (reg_rd_data[7:6] == 2'b00)
        else $error("reserved bits not zero");
    a_rate_e3: assert property (reg_rd_data[2] |-> rate_mode == CCP_RATE_E3)
        else $error("E3 rate not selected");
    a_rate_t_sonet: assert property (!reg_rd_data[2] |-> rate_mode == (reg_rd_data[1] ? CCP_RATE_STS1 : CCP_RATE_DS3))
        else $error("wrong DS3 or STS-1 rate");
    a_loop_select: assert property (loop_mode == {reg_rd_data[3], reg_rd_data[4]})
        else $error("wrong loop mode");
    a_single_rail: assert property (coder_enable == (reg_rd_data[0] | reg_rd_data[5]))
        else $error("coder enable wrong");
    a_err_count: assert property (rx_bit_en && reg_rd_data[5] && !reg_wr_en && loop_mode != CCP_LOOP_DIGITAL
        && prbs_error_count != 16'hFFFF |=> prbs_error_count == $past(prbs_error_count) + 16'(neg_rail_violation_out))
        else $error("error count does not follow flag");
    a_count_idle: assert property (!rx_bit_en && loop_mode != CCP_LOOP_DIGITAL |=> $stable(prbs_error_count))
        else $error("count moved without a bit");
    a_prbs_no_neg: assert property (reg_rd_data[5] && $past(reg_rd_data[5]) && $changed(tx_line) |-> !tx_line.neg)
        else $error("negative rail sent in test");
endmodule

// ==== bench/ccp_channel_control_tb.sv ====
// Testbench for the channel control block
`timescale 1ns/1ps
module ccp_channel_control_tb;
    import ccp_pkg::*;
    logic clock = 1'b0;
    logic rst = 1'b1;
    logic reg_wr_en = 1'b0;
    logic [7:0] reg_wr_data = 8'h00;
    logic rx_bit_en = 1'b0;
    ccp_rails_s rx_line = 2'b00;
    logic rx_cv = 1'b0;
    logic tx_clock_in, tx_positive_in, tx_negative_in;
    logic [7:0] reg_rd_data;
    ccp_rails_s tx_line;
    logic rx_positive_out, rx_negative_out, neg_rail_violation_out, coder_enable;
    ccp_rate_e rate_mode;
    ccp_loop_e loop_mode;
    logic [15:0] prbs_error_count;
    int error_cnt = 0;
    int n_compared = 0;
    int i;
    logic [15:0] flags;
    logic q [$];
    initial forever #5 clock = ~clock;
    ccp_framer_model framer (.clock(clock), .tx_clock_in(tx_clock_in), .tx_positive_in(tx_positive_in),
        .tx_negative_in(tx_negative_in));
    ccp_channel_control dut (.clock(clock), .rst(rst), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
        .reg_rd_data(reg_rd_data), .tx_clock_in(tx_clock_in), .tx_positive_in(tx_positive_in),
        .tx_negative_in(tx_negative_in), .tx_line(tx_line), .rx_bit_en(rx_bit_en), .rx_line(rx_line),
        .rx_code_violation(rx_cv), .rx_positive_out(rx_positive_out), .rx_negative_out(rx_negative_out),
        .neg_rail_violation_out(neg_rail_violation_out), .coder_enable(coder_enable), .rate_mode(rate_mode),
        .loop_mode(loop_mode), .prbs_error_count(prbs_error_count));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr(input logic [7:0] v);
        reg_wr_en <= 1'b1;
        reg_wr_data <= v;
        @(posedge clock);
        reg_wr_en <= 1'b0;
        @(posedge clock);
    endtask
    task automatic rx(input logic p, input logic n);
        rx_bit_en <= 1'b1;
        rx_line <= {p, n};
        @(posedge clock);
        rx_bit_en <= 1'b0;
        @(posedge clock);
    endtask
    // Sequence check needs no seed knowledge: any stage obeys the tap recurrence
    task automatic gen(input logic [7:0] v, input int p, input int t);
        int k;
        wr(v);
        q = {};
        repeat (2) @(negedge tx_clock_in);
        for (k = 0; k < 52; k++) begin
            @(negedge tx_clock_in);
            q.push_back(tx_line.pos);
            chk(tx_line.neg, 1'b0);
            if (k >= p) chk(q[k], q[k - p] ^ q[k - t]);
        end
    endtask
    task automatic conclude();
        $display("compared %0d errors %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    initial begin
        #50000;
        error_cnt++;
        conclude();
    end
    // ----
    // Tests
    // ----
    initial begin
        repeat (8) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        chk(reg_rd_data, CCP_CTRL_RESET);
        wr(8'hFF);
        chk(reg_rd_data, 8'h3F);
        for (i = 0; i < 4; i++) begin
            wr(8'(i << 3));
            chk(loop_mode, {i[0], i[1]});
        end
        wr(8'h06);
        chk(rate_mode, CCP_RATE_E3);
        wr(8'h02);
        chk(rate_mode, CCP_RATE_STS1);
        wr(8'h00);
        chk(rate_mode, CCP_RATE_DS3);
        rx(1'b1, 1'b1);
        chk(rx_negative_out, 1'b1);
        wr(8'h01);
        rx_cv <= 1'b1;
        rx(1'b1, 1'b1);
        chk({rx_positive_out, rx_negative_out}, 2'b10);
        chk(neg_rail_violation_out, 1'b1);
        // Framer toggles its positive pin each bit and copies the old one to the negative pin
        repeat (2) @(negedge tx_clock_in);
        chk(tx_line, {~tx_positive_in, 1'b0});
        wr(8'h00);
        repeat (2) @(negedge tx_clock_in);
        chk(tx_line, {~tx_positive_in, tx_positive_in});
        wr(8'h10);
        rx(1'b1, 1'b0);
        chk(neg_rail_violation_out, 1'b0);
        repeat (2) @(negedge tx_clock_in);
        chk(tx_line, 2'b10);
        wr(8'h18);
        repeat (2) @(negedge tx_clock_in);
        chk({rx_positive_out, rx_negative_out}, {~tx_positive_in, tx_positive_in});
        gen(8'h21, 15, 14);
        wr(8'h00);
        wr(8'h20);
        flags = 0;
        // One flipped bit past the sync span is seen at its own place and at both taps
        for (i = 0; i < 50; i++) begin
            rx(q[i] ^ (i == 30), 1'b0);
            flags += neg_rail_violation_out;
        end
        rx_cv <= 1'b0;
        chk(flags, 3);
        chk(prbs_error_count, 16'h0003);
        gen(8'h26, 23, 18);
        conclude();
    end
endmodule
bind ccp_channel_control ccp_channel_control_checker u_chk (.clock(clock), .rst(rst), .reg_wr_en(reg_wr_en),
    .reg_wr_data(reg_wr_data), .reg_rd_data(reg_rd_data), .rx_bit_en(rx_bit_en), .tx_line(tx_line),
    .neg_rail_violation_out(neg_rail_violation_out), .coder_enable(coder_enable), .rate_mode(rate_mode),
    .loop_mode(loop_mode), .prbs_error_count(prbs_error_count));
